// ### rpm_bank.sv
// Purpose: Read-only receive power monitor registers behind the management port.
// Assumes: The management slave decodes frames and presents word accesses here.
// Notes:   Reads answer one cycle after the strobe; writes are dropped.
//          Total receive current power has no word in this bank.
//
// Contract
// RULE_01: Each input detector quantity is four words ordered xpol_inphase, xpol_quadrature, ypol_inphase, ypol_quadrature.
// RULE_02: The features word reports the input detector kind and readings follow that kind.
// RULE_03: A strength indicator detector reads as signed power in 0.01 dBm counts.
// RULE_04: A peak or mean detector reads as unsigned current in 0.1 microamp counts.
// RULE_05: Each current reading has average, minimum and maximum over the monitoring interval.
// RULE_06: Provisioned channel power reads as signed 0.01 dBm counts.
// RULE_07: Total receive power has average, minimum and maximum in signed 0.01 dBm counts.
// RULE_08: Post attenuator power has two instances of each statistic in signed 0.01 dBm counts.
// RULE_09: Output detector readings are unsigned 25 microvolt counts, four per channel order.
// RULE_10: All monitor registers are read-only and writes change nothing.
// RULE_11: Each new interval restarts accumulation and publishes the previous interval; the code skips publishing an interval with no valid sample.
`timescale 1ns/1ps
module rpm_bank #(
  parameter logic [1:0] DET_KIND  = rpm_pkg::DET_STRENGTH,
  parameter int         AVG_SHIFT = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        pm_start_i,
  input  wire logic [63:0] rfin_sample_i,
  input  wire logic        rfin_valid_i,
  input  wire logic [63:0] rfout_sample_i,
  input  wire logic        rfout_valid_i,
  input  wire logic [15:0] prov_power_i,
  input  wire logic        prov_valid_i,
  input  wire logic [15:0] total_power_i,
  input  wire logic        total_valid_i,
  input  wire logic [31:0] post_power_i,
  input  wire logic        post_valid_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o
);
  import rpm_pkg::*;

  // ------------------------------------------------------------------
  // Statistic slots
  // ------------------------------------------------------------------
  logic [15:0] smp    [SLOT_COUNT];
  logic        vld    [SLOT_COUNT];
  logic        sgn    [SLOT_COUNT];
  logic [15:0] cur    [SLOT_COUNT];
  logic [15:0] avg    [SLOT_COUNT];
  logic [15:0] mn     [SLOT_COUNT];
  logic [15:0] mx     [SLOT_COUNT];
  logic        rf_signed;
  logic [15:0] features;

  // ------------------------------------------------------------------
  // Detector kind
  // ------------------------------------------------------------------
  // RULE_02: kind drives encoding
  assign rf_signed = (DET_KIND == DET_STRENGTH);
  assign features  = 16'(DET_KIND) << DET_TYPE_POS;

  // One statistic engine per slot; the slot order is fixed by the package.
  genvar g;
  generate
    for (g = 0; g < SLOT_COUNT; g++) begin : g_slot
      if (g < SLOT_PROV) begin : g_rfin
        // RULE_01: channel order by slice
        assign smp[g] = rfin_sample_i[16*g +: 16];
        assign vld[g] = rfin_valid_i;
        // RULE_03: signed strength counts
        // RULE_04: unsigned peak or mean
        assign sgn[g] = rf_signed;
      end else if (g == SLOT_PROV) begin : g_prov
        // RULE_06: provisioned signed power
        assign smp[g] = prov_power_i;
        assign vld[g] = prov_valid_i;
        assign sgn[g] = 1'b1;
      end else if (g == SLOT_TOTAL) begin : g_total
        // RULE_07: total signed power
        assign smp[g] = total_power_i;
        assign vld[g] = total_valid_i;
        assign sgn[g] = 1'b1;
      end else if (g < SLOT_RFOUT) begin : g_post
        // RULE_08: two attenuator instances
        assign smp[g] = post_power_i[16*(g-SLOT_POST) +: 16];
        assign vld[g] = post_valid_i;
        assign sgn[g] = 1'b1;
      end else begin : g_rfout
        // RULE_09: unsigned output detector
        assign smp[g] = rfout_sample_i[16*(g-SLOT_RFOUT) +: 16];
        assign vld[g] = rfout_valid_i;
        assign sgn[g] = 1'b0;
      end
      rpm_stat #(
        .AVG_SHIFT (AVG_SHIFT)
      ) u_stat (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .sample_i  (smp[g]),
        .valid_i   (vld[g]),
        .signed_i  (sgn[g]),
        .restart_i (pm_start_i),
        .cur_o     (cur[g]),
        .avg_o     (avg[g]),
        .min_o     (mn[g]),
        .max_o     (mx[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------------
  // True when the address falls in a block of n consecutive words.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                               input int n);
    hit = (a >= base) && (a < base + 16'(n));
  endfunction

  logic [15:0] rd_nxt;
  logic [15:0] off;
  logic        unused_wr;

  // ------------------------------------------------------------------
  // Write port
  // ------------------------------------------------------------------
  // Writes are consumed here only so that no input is left dangling.
  // RULE_10: writes never reach storage
  assign unused_wr = reg_wr_i & (|reg_wdata_i);

  // Decode is combinational; the answer register below retimes it.
  always_comb begin
    // Unmapped words read as zero.
    rd_nxt = UNMAPPED_READ;
    off    = '0;
    // RULE_02: features word
    if (reg_addr_i == AMPLIFIER_FEATURES_REGISTER) begin
      rd_nxt = features;
    // RULE_01: input detector words
    end else if (hit(reg_addr_i, RF_INPUT_DETECTOR_CURRENT, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_INPUT_DETECTOR_CURRENT;
      rd_nxt = cur[SLOT_RFIN + int'(off[1:0])];
    // RULE_05: input detector statistics
    end else if (hit(reg_addr_i, RF_INPUT_DETECTOR_AVERAGE, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_INPUT_DETECTOR_AVERAGE;
      rd_nxt = avg[SLOT_RFIN + int'(off[1:0])];
    end else if (hit(reg_addr_i, RF_INPUT_DETECTOR_MINIMUM, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_INPUT_DETECTOR_MINIMUM;
      rd_nxt = mn[SLOT_RFIN + int'(off[1:0])];
    end else if (hit(reg_addr_i, RF_INPUT_DETECTOR_MAXIMUM, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_INPUT_DETECTOR_MAXIMUM;
      rd_nxt = mx[SLOT_RFIN + int'(off[1:0])];
    // RULE_09: output detector words
    end else if (hit(reg_addr_i, RF_OUTPUT_DETECTOR_CURRENT, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_OUTPUT_DETECTOR_CURRENT;
      rd_nxt = cur[SLOT_RFOUT + int'(off[1:0])];
    end else if (hit(reg_addr_i, RF_OUTPUT_DETECTOR_AVERAGE, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_OUTPUT_DETECTOR_AVERAGE;
      rd_nxt = avg[SLOT_RFOUT + int'(off[1:0])];
    end else if (hit(reg_addr_i, RF_OUTPUT_DETECTOR_MINIMUM, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_OUTPUT_DETECTOR_MINIMUM;
      rd_nxt = mn[SLOT_RFOUT + int'(off[1:0])];
    end else if (hit(reg_addr_i, RF_OUTPUT_DETECTOR_MAXIMUM, FRONTEND_CHANNELS)) begin
      off    = reg_addr_i - RF_OUTPUT_DETECTOR_MAXIMUM;
      rd_nxt = mx[SLOT_RFOUT + int'(off[1:0])];
    // RULE_06: provisioned channel words
    end else if (reg_addr_i == PROVISIONED_CHANNEL_POWER_CURRENT) begin
      rd_nxt = cur[SLOT_PROV];
    end else if (reg_addr_i == PROVISIONED_CHANNEL_POWER_AVERAGE) begin
      rd_nxt = avg[SLOT_PROV];
    end else if (reg_addr_i == PROVISIONED_CHANNEL_POWER_MINIMUM) begin
      rd_nxt = mn[SLOT_PROV];
    end else if (reg_addr_i == PROVISIONED_CHANNEL_POWER_MAXIMUM) begin
      rd_nxt = mx[SLOT_PROV];
    // RULE_07: total power statistics
    end else if (reg_addr_i == TOTAL_RX_POWER_AVERAGE) begin
      rd_nxt = avg[SLOT_TOTAL];
    end else if (reg_addr_i == TOTAL_RX_POWER_MINIMUM) begin
      rd_nxt = mn[SLOT_TOTAL];
    end else if (reg_addr_i == TOTAL_RX_POWER_MAXIMUM) begin
      rd_nxt = mx[SLOT_TOTAL];
    // The instance is picked by address bit 0, as every base is even.
    // RULE_08: post attenuator words
    end else if (hit(reg_addr_i, POST_ATTENUATOR_POWER_CURRENT, ATTENUATOR_TARGETS)) begin
      rd_nxt = cur[SLOT_POST + int'(reg_addr_i[0])];
    end else if (hit(reg_addr_i, POST_ATTENUATOR_POWER_AVERAGE, ATTENUATOR_TARGETS)) begin
      rd_nxt = avg[SLOT_POST + int'(reg_addr_i[0])];
    end else if (hit(reg_addr_i, POST_ATTENUATOR_POWER_MINIMUM, ATTENUATOR_TARGETS)) begin
      rd_nxt = mn[SLOT_POST + int'(reg_addr_i[0])];
    end else if (hit(reg_addr_i, POST_ATTENUATOR_POWER_MAXIMUM, ATTENUATOR_TARGETS)) begin
      rd_nxt = mx[SLOT_POST + int'(reg_addr_i[0])];
    end
  end

  // ------------------------------------------------------------------
  // Read answer
  // ------------------------------------------------------------------
  // Read data is held until the next read so a slow serial shifter can use it.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= MONITOR_RESET;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Answer strobe
  // ------------------------------------------------------------------
  // A flop, not the strobe itself, so the answer always lands one cycle later.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

endmodule

// ### rpm_bank_checker.sv
// Purpose: Port checks for the receive power monitor register bank.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes:   Attached to every bank instance by the bind after the module.
`timescale 1ns/1ps
module rpm_bank_checker #(
  parameter logic [1:0] DET_KIND = rpm_pkg::DET_STRENGTH
) (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [15:0] prov_power_i,
  input wire logic        prov_valid_i,
  input wire logic [31:0] post_power_i,
  input wire logic        post_valid_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o
);
  import rpm_pkg::*;
  // Last accepted samples; a read in the sampling cycle itself is ambiguous and skipped.
  logic [15:0] prov_q;
  logic [15:0] post_hi_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prov_q    <= MONITOR_RESET;
      post_hi_q <= MONITOR_RESET;
    end else begin
      if (prov_valid_i) prov_q <= prov_power_i;
      if (post_valid_i) post_hi_q <= post_power_i[31:16];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  no_answer_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without a read");
  data_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  write_quiet_a: assert property (reg_wr_i && !reg_rd_i |=>
      !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("write produced an answer");
  feat_kind_a: assert property (reg_rd_i && reg_addr_i == AMPLIFIER_FEATURES_REGISTER
      |=> reg_rdata_o == {14'h0, DET_KIND})
    else $error("features word wrong");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 16'h0000
      |=> reg_rdata_o == UNMAPPED_READ)
    else $error("unmapped read not zero");
  prov_cur_a: assert property (reg_rd_i && !prov_valid_i &&
      reg_addr_i == PROVISIONED_CHANNEL_POWER_CURRENT |=> reg_rdata_o == $past(prov_q))
    else $error("provisioned current word wrong");
  post_second_a: assert property (reg_rd_i && !post_valid_i &&
      reg_addr_i == POST_ATTENUATOR_POWER_CURRENT + 16'h1 |=> reg_rdata_o == $past(post_hi_q))
    else $error("second post attenuator word wrong");
  cover property (prov_valid_i ##[1:4] reg_rd_i);
  cover property (reg_wr_i ##[1:4] reg_rd_i);
  cover property (reg_rvalid_o && reg_rdata_o[15]);
endmodule

bind rpm_bank rpm_bank_checker #(.DET_KIND(DET_KIND)) u_rpm_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .prov_power_i(prov_power_i), .prov_valid_i(prov_valid_i),
  .post_power_i(post_power_i), .post_valid_i(post_valid_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o));

// ### rpm_host_model.sv
// Purpose: Host management controller issuing word reads and writes to the bank.
// Assumes: A read is answered exactly one cycle after its strobe edge.
// Notes:   Released address and data lines are inverted so stale values never match.
`timescale 1ns/1ps
module rpm_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [15:0] addr_o,
  output logic      [15:0] wdata_o
);
  initial begin
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 16'h0000;
    wdata_o = 16'h0000;
  end
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    // The answer is taken at the edge where it stands, before the bank moves on.
    @(posedge clk_i);
    ok     = (rvalid_i === 1'b1);
    d      = rdata_i;
    addr_o <= ~a;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
endmodule

// ### rpm_pkg.sv
// Purpose: Shared constants for the receive power monitor register bank.
// Assumes: Register offsets are the management word addresses of the module.
// Notes:   All monitor words are 16 bits wide and read-only.
package rpm_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [15:0] AMPLIFIER_FEATURES_REGISTER        = 16'hbb8c;
  localparam logic [15:0] RF_OUTPUT_DETECTOR_CURRENT         = 16'hbbd4;
  localparam logic [15:0] RF_OUTPUT_DETECTOR_AVERAGE         = 16'hbbd8;
  localparam logic [15:0] RF_OUTPUT_DETECTOR_MINIMUM         = 16'hbbdc;
  localparam logic [15:0] RF_OUTPUT_DETECTOR_MAXIMUM         = 16'hbbe0;
  localparam logic [15:0] RF_INPUT_DETECTOR_CURRENT          = 16'hbbe4;
  localparam logic [15:0] RF_INPUT_DETECTOR_AVERAGE          = 16'hbbe8;
  localparam logic [15:0] RF_INPUT_DETECTOR_MINIMUM          = 16'hbbec;
  localparam logic [15:0] RF_INPUT_DETECTOR_MAXIMUM          = 16'hbbf0;
  localparam logic [15:0] PROVISIONED_CHANNEL_POWER_CURRENT  = 16'hbbf4;
  localparam logic [15:0] PROVISIONED_CHANNEL_POWER_AVERAGE  = 16'hbbf5;
  localparam logic [15:0] PROVISIONED_CHANNEL_POWER_MINIMUM  = 16'hbbf6;
  localparam logic [15:0] PROVISIONED_CHANNEL_POWER_MAXIMUM  = 16'hbbf7;
  localparam logic [15:0] POST_ATTENUATOR_POWER_CURRENT      = 16'hbbf8;
  localparam logic [15:0] POST_ATTENUATOR_POWER_AVERAGE      = 16'hbbfa;
  localparam logic [15:0] POST_ATTENUATOR_POWER_MINIMUM      = 16'hbbfc;
  localparam logic [15:0] POST_ATTENUATOR_POWER_MAXIMUM      = 16'hbbfe;
  localparam logic [15:0] TOTAL_RX_POWER_AVERAGE             = 16'hb4f0;
  localparam logic [15:0] TOTAL_RX_POWER_MINIMUM             = 16'hb500;
  localparam logic [15:0] TOTAL_RX_POWER_MAXIMUM             = 16'hb510;

  // ------------------------------------------------------------------
  // Layout and reset values
  // ------------------------------------------------------------------
  localparam int          FRONTEND_CHANNELS   = 4;
  localparam int          ATTENUATOR_TARGETS  = 2;
  localparam int          DET_TYPE_POS        = 0;
  localparam logic [15:0] MONITOR_RESET       = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ       = 16'h0000;

  // Input detector kinds as reported in the features word.
  localparam logic [1:0]  DET_STRENGTH        = 2'h0;
  localparam logic [1:0]  DET_PEAK            = 2'h1;
  localparam logic [1:0]  DET_MEAN            = 2'h2;

  // Statistic slots: input detector, provisioned, total, post, output detector.
  localparam int          SLOT_RFIN           = 0;
  localparam int          SLOT_PROV           = 4;
  localparam int          SLOT_TOTAL          = 5;
  localparam int          SLOT_POST           = 6;
  localparam int          SLOT_RFOUT          = 8;
  localparam int          SLOT_COUNT          = 12;

endpackage

// ### rpm_stat.sv
// Purpose: Current, average, minimum and maximum of one monitored quantity.
// Assumes: restart_i pulses once at the start of each monitoring interval.
// Notes:   The average is an exponential filter reseeded at each interval.
`timescale 1ns/1ps
module rpm_stat #(
  parameter int AVG_SHIFT = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] sample_i,
  input  wire logic        valid_i,
  input  wire logic        signed_i,
  input  wire logic        restart_i,
  output logic      [15:0] cur_o,
  output logic      [15:0] avg_o,
  output logic      [15:0] min_o,
  output logic      [15:0] max_o
);
  import rpm_pkg::*;

  logic signed [16:0] x_ext;
  logic signed [16:0] avg_r;
  logic signed [16:0] min_r;
  logic signed [16:0] max_r;
  logic signed [17:0] diff;
  logic signed [16:0] avg_nxt;
  logic               empty_r;

  // Extending by the detector sign lets one comparator serve both encodings.
  assign x_ext   = signed_i ? {sample_i[15], sample_i} : {1'b0, sample_i};
  assign diff    = {x_ext[16], x_ext} - {avg_r[16], avg_r};
  assign avg_nxt = avg_r + 17'(diff >>> AVG_SHIFT);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_o <= MONITOR_RESET;
    end else if (valid_i) begin
      cur_o <= sample_i;
    end
  end

  // RULE_11: restart then publish
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_o <= MONITOR_RESET;
      min_o <= MONITOR_RESET;
      max_o <= MONITOR_RESET;
    end else if (restart_i && !empty_r) begin
      avg_o <= avg_r[15:0];
      min_o <= min_r[15:0];
      max_o <= max_r[15:0];
    end
  end

  // RULE_05: running interval statistics
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_r   <= '0;
      min_r   <= '0;
      max_r   <= '0;
      empty_r <= 1'b1;
    end else if (valid_i && (restart_i || empty_r)) begin
      avg_r   <= x_ext;
      min_r   <= x_ext;
      max_r   <= x_ext;
      empty_r <= 1'b0;
    end else if (valid_i) begin
      avg_r <= avg_nxt;
      if (x_ext < min_r) begin
        min_r <= x_ext;
      end
      if (x_ext > max_r) begin
        max_r <= x_ext;
      end
    end else if (restart_i) begin
      empty_r <= 1'b1;
    end
  end

endmodule

// ### test_rx_power_monitor_registers.sv
// Purpose: Self-checking bench for the receive power monitor register bank.
// Assumes: Strength indicator bank, a peak detector bank beside it, filter weight one half.
// Notes:   Ordinary reads come from a row table; later tests are hand-written.
`timescale 1ns/1ps
`define RPM_CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("[FAIL] %0t read %h expected %h", $time, got, exp); \
    end \
  end
module test_rx_power_monitor_registers;
  import rpm_pkg::*;
  localparam int AVGS = 1;
  typedef struct packed { logic [15:0] a; logic [15:0] e; } rpm_row_t;
  typedef logic [11:0][15:0] rpm_smp_t;
  // Slot order: input ch0-3, provisioned, total, post 0-1, output ch0-3 (from bit 0 up).
  localparam rpm_smp_t S0 = {16'hfff0, 16'h0030, 16'h0020, 16'h0010, 16'h0020, 16'hffe0,
                             16'hff38, 16'hff00, 16'hfff0, 16'h0030, 16'h0020, 16'h0010};
  localparam rpm_smp_t S1 = {16'h0005, 16'h0010, 16'h0040, 16'h0008, 16'h0010, 16'h0030,
                             16'h0064, 16'h0010, 16'h0005, 16'h0010, 16'h0040, 16'h0008};
  logic        clk_i, rstn_i, pm_start_i, ok, reg_rd_i, reg_wr_i, reg_rvalid_o;
  logic        rfin_valid_i, rfout_valid_i, prov_valid_i, total_valid_i, post_valid_i;
  logic [63:0] rfin_sample_i, rfout_sample_i;
  logic [31:0] post_power_i;
  logic [15:0] prov_power_i, total_power_i, reg_addr_i, reg_wdata_i, reg_rdata_o, rdat, b, st;
  logic [15:0] pk_rdata;
  logic        pk_rvalid;
  int          err_count = 0;
  int          checks_done = 0;
  int          s, x, y;
  rpm_row_t    rows[$];

  rpm_bank #(.DET_KIND(DET_STRENGTH), .AVG_SHIFT(AVGS)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
    .pm_start_i(pm_start_i), .rfin_sample_i(rfin_sample_i), .rfin_valid_i(rfin_valid_i),
    .rfout_sample_i(rfout_sample_i), .rfout_valid_i(rfout_valid_i),
    .prov_power_i(prov_power_i), .prov_valid_i(prov_valid_i), .total_power_i(total_power_i),
    .total_valid_i(total_valid_i), .post_power_i(post_power_i), .post_valid_i(post_valid_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o));
  rpm_host_model u_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .rd_o(reg_rd_i), .wr_o(reg_wr_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  // A peak detector bank shares every input so the unsigned encoding is exercised.
  rpm_bank #(.DET_KIND(DET_PEAK), .AVG_SHIFT(AVGS)) uut_pk (.clk_i(clk_i), .rstn_i(rstn_i),
    .pm_start_i(pm_start_i), .rfin_sample_i(rfin_sample_i), .rfin_valid_i(rfin_valid_i),
    .rfout_sample_i(rfout_sample_i), .rfout_valid_i(rfout_valid_i),
    .prov_power_i(prov_power_i), .prov_valid_i(prov_valid_i), .total_power_i(total_power_i),
    .total_valid_i(total_valid_i), .post_power_i(post_power_i), .post_valid_i(post_valid_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(pk_rdata), .reg_rvalid_o(pk_rvalid));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // First word address and statistic stride of each slot.
  function automatic logic [31:0] loc(input int n);
    case (n) inside
      [0:3]:   return {RF_INPUT_DETECTOR_CURRENT + 16'(n), 16'h4};
      4:       return {PROVISIONED_CHANNEL_POWER_CURRENT, 16'h1};
      5:       return {TOTAL_RX_POWER_AVERAGE - 16'h10, 16'h10};
      [6:7]:   return {POST_ATTENUATOR_POWER_CURRENT + 16'(n - 6), 16'h2};
      default: return {RF_OUTPUT_DETECTOR_CURRENT + 16'(n - 8), 16'h4};
    endcase
  endfunction
  task automatic drive(input rpm_smp_t w, input logic v);
    rpm_smp_t d = v ? w : ~w;
    @(posedge clk_i);
    rfin_sample_i  <= d[3:0];
    rfout_sample_i <= d[11:8];
    post_power_i   <= d[7:6];
    prov_power_i   <= d[SLOT_PROV];
    total_power_i  <= d[SLOT_TOTAL];
    {rfin_valid_i, rfout_valid_i, prov_valid_i, total_valid_i, post_valid_i} <= {5{v}};
  endtask
  task automatic restart();
    @(posedge clk_i);
    pm_start_i <= 1'b1;
    @(posedge clk_i);
    pm_start_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    u_host.rd(a, rdat, ok);
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t no answer to read of %h", $time, a);
    end else begin
      `RPM_CHK(rdat, e)
    end
  endtask
  // The peak bank answers in the same cycle, so its word is taken at the same edge.
  task automatic rdp(input logic [15:0] a, input logic [15:0] e, input logic [15:0] ep);
    rdc(a, e);
    `RPM_CHK({pk_rvalid, pk_rdata}, {1'b1, ep})
  endtask

  initial begin
    {rstn_i, pm_start_i, rfin_valid_i, rfout_valid_i, prov_valid_i, total_valid_i} = '0;
    {post_valid_i, rfin_sample_i, rfout_sample_i, post_power_i} = '0;
    {prov_power_i, total_power_i} = '0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    restart();
    drive(S0, 1'b1);
    drive(S1, 1'b1);
    drive(S1, 1'b0);
    restart();
    rows.push_back('{AMPLIFIER_FEATURES_REGISTER, {14'h0, DET_STRENGTH}});
    rows.push_back('{16'h0000, UNMAPPED_READ});
    for (s = 0; s < 12; s++) begin
      {b, st} = loc(s);
      x = (s < 8) ? int'($signed(S0[s])) : int'(S0[s]);
      y = (s < 8) ? int'($signed(S1[s])) : int'(S1[s]);
      if (s != SLOT_TOTAL) rows.push_back('{b, S1[s]});
      rows.push_back('{b + st, 16'(x + ((y - x) >>> AVGS))});
      rows.push_back('{b + st + st, 16'((x < y) ? x : y)});
      rows.push_back('{b + st + st + st, 16'((x > y) ? x : y)});
    end
    foreach (rows[i]) rdc(rows[i].a, rows[i].e);
    $display("table test finished, %0d rows", rows.size());
    rdp(AMPLIFIER_FEATURES_REGISTER, {14'h0, DET_STRENGTH}, {14'h0, DET_PEAK});
    rdp(RF_INPUT_DETECTOR_MINIMUM + 16'h3, 16'hfff0, 16'h0005);
    rdp(RF_INPUT_DETECTOR_MAXIMUM + 16'h3, 16'h0005, 16'hfff0);
    rdp(RF_INPUT_DETECTOR_AVERAGE + 16'h3, 16'hfffa, 16'h7ffa);
    $display("detector kind test finished");
    drive({12{16'h0001}}, 1'b1);
    drive({12{16'h0001}}, 1'b0);
    rdc(RF_INPUT_DETECTOR_CURRENT, 16'h0001);
    rdc(RF_INPUT_DETECTOR_MINIMUM, S1[SLOT_RFIN]);
    restart();
    rdc(RF_INPUT_DETECTOR_MAXIMUM, 16'h0001);
    restart();
    rdc(RF_INPUT_DETECTOR_MINIMUM, 16'h0001);
    $display("interval test finished");
    u_host.wr(RF_INPUT_DETECTOR_CURRENT, 16'hffff);
    u_host.wr(AMPLIFIER_FEATURES_REGISTER, 16'hffff);
    rdc(RF_INPUT_DETECTOR_CURRENT, 16'h0001);
    rdc(AMPLIFIER_FEATURES_REGISTER, {14'h0, DET_STRENGTH});
    $display("write test finished");
    rstn_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(RF_INPUT_DETECTOR_CURRENT, MONITOR_RESET);
    rdc(POST_ATTENUATOR_POWER_MAXIMUM + 16'h1, MONITOR_RESET);
    $display("reset test finished");
    print_verdict();
  end
endmodule
